// ### verilog/eie_pkg.sv
// Constants, field layout and types of the port interrupt event logic.
// Assumes a Wishbone slave with byte addresses and 32-bit data.
// Contract
// - Config registers visible only in mode 111
// - Level events pulsed, masked while clock frozen
// - Terminal count pulse when DMA enabled
// - Forward interrupt with eight or more free
// - Service clear also fires forward, some modes
// - Backward interrupt with eight or more waiting
// - Service clear also fires backward, some modes
// - Error falling edge or mask cleared while asserted
// - Error event may be lost while frozen
// - Acknowledge rising edge interrupt when enabled
// - Request pulses the cycle after any event
// - DMA enabled: enable bit set, service clear
// - Direction bit set means backward transfer
package eie_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam int CNT_W = 5;
  localparam int EV_N = 5;
  localparam logic [7:0] OFS_XCTL = 8'h00;
  localparam logic [7:0] OFS_DCTL = 8'h04;
  localparam logic [7:0] OFS_CFGA = 8'h08;
  localparam logic [7:0] OFS_CFGB = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FIFO = 8'h18;
  localparam int XCTL_MODE_LSB = 5;
  localparam int XCTL_ERRM = 4;
  localparam int XCTL_DMAEN = 3;
  localparam int XCTL_SVC = 2;
  localparam int XCTL_FULL = 1;
  localparam int XCTL_EMPTY = 0;
  localparam int DCTL_DIR = 5;
  localparam int DCTL_ACKEN = 4;
  localparam int FIFO_FILL_LSB = 8;
  localparam int EV_TC = 0;
  localparam int EV_FWD = 1;
  localparam int EV_BWD = 2;
  localparam int EV_ERR = 3;
  localparam int EV_ACK = 4;
  localparam int PIN_ERR = 0;
  localparam int PIN_ACK = 1;
  localparam logic [2:0] MODE_CAP = 3'h2;
  localparam logic [2:0] MODE_CAPF = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  localparam logic [REG_W-1:0] XCTL_RST = 8'h14;
  localparam logic [REG_W-1:0] DCTL_RST = 8'h00;
  localparam logic [REG_W-1:0] CFGA_RST = 8'h10;
  localparam logic [REG_W-1:0] CFGB_RST = 8'h00;
  localparam logic [EV_N-1:0] STAT_RST = 5'h00;
  localparam logic [EV_N-1:0] MASK_RST = 5'h00;
  localparam logic [CNT_W-1:0] FIFO_THR = 5'h08;
  typedef enum logic [1:0]
  {
    WB_IDLE = 2'b00,
    WB_ACK = 2'b01,
    WB_DONE = 2'b11
  } eie_wb_st_t;
endpackage

// ### verilog/eie_pin_if.sv
// Synchronised pin levels and edges passed inside the block.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface eie_pin_if;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  modport src
  (
    output lvl,
    output rise,
    output fall
  );
  modport dst
  (
    input lvl,
    input rise,
    input fall
  );
endinterface

// ### verilog/eie_pin_sync.sv
// Two-stage synchronisers and edge detection for the status pins.
// Assumes asynchronous pins idling high.
`timescale 1ns/10ps
module eie_pin_sync
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] pin_in,
  eie_pin_if.src pins
);
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  ////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          s1_reg[i] <= 1'b1;
          s2_reg[i] <= 1'b1;
          s3_reg[i] <= 1'b1;
        end
        else if (clk_en)
        begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
        end
      end
      assign pins.lvl[i] = s2_reg[i];
      assign pins.rise[i] = s2_reg[i] & ~s3_reg[i];
      assign pins.fall[i] = ~s2_reg[i] & s3_reg[i];
    end
  endgenerate
endmodule // eie_pin_sync

// ### verilog/eie_lvl_pulse.sv
// Turns level conditions into one-cycle pulses on their rising edge.
// Assumes levels come from logic on sys_clk.
`timescale 1ns/10ps
module eie_lvl_pulse
#(
  parameter int N = 2
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic freeze,
  input wire logic [N-1:0] lvl,
  output logic [N-1:0] pulse
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] lvl_m;
  ////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      assign lvl_m[i] = lvl[i] & ~freeze;
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          prev_reg[i] <= 1'b0;
        else if (clk_en)
          prev_reg[i] <= lvl_m[i];
      end
      assign pulse[i] = lvl_m[i] & ~prev_reg[i];
    end
  endgenerate
endmodule // eie_lvl_pulse

// ### verilog/eie_top.sv
// Interrupt event logic of the extended capability port.
// Assumes FIFO counts, DMA strobes and freeze flag on sys_clk; pins async.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module eie_top
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [eie_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [eie_pkg::DAT_W-1:0] wb_dat_i,
  output logic [eie_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dma_tc,
  input wire logic dma_cycle,
  input wire logic [eie_pkg::CNT_W-1:0] fifo_free,
  input wire logic [eie_pkg::CNT_W-1:0] fifo_fill,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic core_clk_frozen,
  input wire logic err_n_pin,
  input wire logic ack_n_pin,
  output logic [eie_pkg::REG_W-1:0] extended_control,
  output logic [eie_pkg::REG_W-1:0] device_control,
  output logic [eie_pkg::REG_W-1:0] port_config_a,
  output logic [eie_pkg::REG_W-1:0] port_config_b,
  output logic dma_enabled,
  output logic irq_req,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  eie_pkg::eie_wb_st_t wb_st_reg;
  eie_pkg::eie_wb_st_t wb_st_next;
  logic [eie_pkg::REG_W-1:0] xctl_reg;
  logic [eie_pkg::REG_W-1:0] dctl_reg;
  logic [eie_pkg::REG_W-1:0] cfga_reg;
  logic [eie_pkg::REG_W-1:0] cfgb_reg;
  logic [eie_pkg::EV_N-1:0] stat_reg;
  logic [eie_pkg::EV_N-1:0] stat_next;
  logic [eie_pkg::EV_N-1:0] mask_reg;
  logic [eie_pkg::DAT_W-1:0] rdat_reg;
  logic [eie_pkg::DAT_W-1:0] rdat_next;
  logic ack_reg;
  logic irq_req_reg;
  logic irq_reg;
  logic dma_en_reg;
  logic svc_clr_reg;
  logic errm_clr_reg;
  logic tc_prev_reg;
  logic wr_go;
  logic wr_lane;
  logic [eie_pkg::REG_W-1:0] wbyte;
  logic [2:0] mode;
  logic cfg_vis;
  logic svc;
  logic dma_en;
  logic dir_bwd;
  logic tc_lvl;
  logic [1:0] thr_lvl;
  logic [1:0] thr_rise;
  logic [eie_pkg::EV_N-1:0] ev;
  logic [eie_pkg::EV_N-1:0] w1c;
  eie_pin_if pins ();

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic adr_is
  (
    input logic [eie_pkg::ADR_W-1:0] adr,
    input logic [eie_pkg::ADR_W-1:0] ofs
  );
    adr_is = (adr == ofs);
  endfunction

  function automatic logic mode_fwd_clr
  (
    input logic [2:0] m
  );
    mode_fwd_clr = (m == eie_pkg::MODE_CAP) ||
      (m == eie_pkg::MODE_CAPF) || (m == eie_pkg::MODE_TEST);
  endfunction

  function automatic logic mode_bwd_clr
  (
    input logic [2:0] m
  );
    mode_bwd_clr = (m == eie_pkg::MODE_CAPF) ||
      (m == eie_pkg::MODE_TEST);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Field views
  assign mode = xctl_reg[eie_pkg::XCTL_MODE_LSB +: 3];
  assign svc = xctl_reg[eie_pkg::XCTL_SVC];
  assign cfg_vis = (mode == eie_pkg::MODE_CFG);
  assign dma_en = xctl_reg[eie_pkg::XCTL_DMAEN] & ~svc;
  assign dir_bwd = dctl_reg[eie_pkg::DCTL_DIR];

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave sequencing
  assign wbyte = wb_dat_i[eie_pkg::REG_W-1:0];
  assign wr_lane = wb_sel_i[0];
  assign wr_go = (wb_st_reg == eie_pkg::WB_ACK) & wb_we_i & wr_lane;

  always_comb
  begin
    wb_st_next = wb_st_reg;
    case (wb_st_reg)
      eie_pkg::WB_IDLE:
      begin
        if (wb_cyc_i & wb_stb_i)
          wb_st_next = eie_pkg::WB_ACK;
      end
      eie_pkg::WB_ACK:
        wb_st_next = eie_pkg::WB_DONE;
      eie_pkg::WB_DONE:
        wb_st_next = eie_pkg::WB_IDLE;
      default:
        wb_st_next = eie_pkg::WB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      wb_st_reg <= eie_pkg::WB_IDLE;
    else if (clk_en)
      wb_st_reg <= wb_st_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else if (clk_en)
      ack_reg <= (wb_st_next == eie_pkg::WB_ACK);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    rdat_next = '0;
    if (adr_is(wb_adr_i, eie_pkg::OFS_XCTL))
    begin
      rdat_next[eie_pkg::REG_W-1:0] = xctl_reg;
      rdat_next[eie_pkg::XCTL_FULL] = fifo_full;
      rdat_next[eie_pkg::XCTL_EMPTY] = fifo_empty;
    end
    else if (adr_is(wb_adr_i, eie_pkg::OFS_DCTL))
      rdat_next[eie_pkg::REG_W-1:0] = dctl_reg;
    else if (adr_is(wb_adr_i, eie_pkg::OFS_CFGA) & cfg_vis)
      rdat_next[eie_pkg::REG_W-1:0] = cfga_reg;
    else if (adr_is(wb_adr_i, eie_pkg::OFS_CFGB) & cfg_vis)
      rdat_next[eie_pkg::REG_W-1:0] = cfgb_reg;
    else if (adr_is(wb_adr_i, eie_pkg::OFS_STAT))
      rdat_next[eie_pkg::EV_N-1:0] = stat_reg;
    else if (adr_is(wb_adr_i, eie_pkg::OFS_MASK))
      rdat_next[eie_pkg::EV_N-1:0] = mask_reg;
    else if (adr_is(wb_adr_i, eie_pkg::OFS_FIFO))
    begin
      rdat_next[eie_pkg::CNT_W-1:0] = fifo_free;
      rdat_next[eie_pkg::FIFO_FILL_LSB +: eie_pkg::CNT_W] = fifo_fill;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdat_reg <= '0;
    else if (clk_en)
    begin
      if (wb_st_next == eie_pkg::WB_ACK)
        rdat_reg <= rdat_next;
      else
        rdat_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      xctl_reg <= eie_pkg::XCTL_RST;
      svc_clr_reg <= 1'b0;
      errm_clr_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      svc_clr_reg <= 1'b0;
      errm_clr_reg <= 1'b0;
      if (wr_go & adr_is(wb_adr_i, eie_pkg::OFS_XCTL))
      begin
        xctl_reg <= {wbyte[eie_pkg::REG_W-1:2], 2'h0};
        svc_clr_reg <= svc & ~wbyte[eie_pkg::XCTL_SVC];
        // mask changed from one to zero
        errm_clr_reg <= xctl_reg[eie_pkg::XCTL_ERRM] &
          ~wbyte[eie_pkg::XCTL_ERRM];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      dctl_reg <= eie_pkg::DCTL_RST;
    else if (clk_en & wr_go & adr_is(wb_adr_i, eie_pkg::OFS_DCTL))
      dctl_reg <= wbyte;
  end

  // config writes only in mode 111
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cfga_reg <= eie_pkg::CFGA_RST;
      cfgb_reg <= eie_pkg::CFGB_RST;
    end
    else if (clk_en & wr_go & cfg_vis)
    begin
      if (adr_is(wb_adr_i, eie_pkg::OFS_CFGA))
        cfga_reg <= wbyte;
      if (adr_is(wb_adr_i, eie_pkg::OFS_CFGB))
        cfgb_reg <= wbyte;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mask_reg <= eie_pkg::MASK_RST;
    else if (clk_en & wr_go & adr_is(wb_adr_i, eie_pkg::OFS_MASK))
      mask_reg <= wbyte[eie_pkg::EV_N-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and level shaping
  eie_pin_sync u_sync
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in({ack_n_pin, err_n_pin}),
    .pins(pins.src)
  );

  assign thr_lvl[0] = ~svc & ~xctl_reg[eie_pkg::XCTL_DMAEN] & ~dir_bwd &
    (fifo_free >= eie_pkg::FIFO_THR);
  assign thr_lvl[1] = ~svc & ~xctl_reg[eie_pkg::XCTL_DMAEN] & dir_bwd &
    (fifo_fill >= eie_pkg::FIFO_THR);

  eie_lvl_pulse #(.N(2)) u_thr
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .freeze(core_clk_frozen),
    .lvl(thr_lvl),
    .pulse(thr_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Events
  // terminal count during port DMA
  assign tc_lvl = dma_en & dma_tc & dma_cycle;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tc_prev_reg <= 1'b0;
    else if (clk_en)
      tc_prev_reg <= tc_lvl;
  end

  always_comb
  begin
    ev = '0;
    ev[eie_pkg::EV_TC] = tc_lvl & ~tc_prev_reg;
    // clear path only in 010 011 110
    ev[eie_pkg::EV_FWD] = thr_rise[0] & (~svc_clr_reg | mode_fwd_clr(mode));
    // clear path only in 011 110
    ev[eie_pkg::EV_BWD] = thr_rise[1] & (~svc_clr_reg | mode_bwd_clr(mode));
    // falling edge or mask cleared; lost when frozen
    ev[eie_pkg::EV_ERR] = ~core_clk_frozen &
      ((~xctl_reg[eie_pkg::XCTL_ERRM] & pins.fall[eie_pkg::PIN_ERR]) |
      (errm_clr_reg & ~pins.lvl[eie_pkg::PIN_ERR]));
    ev[eie_pkg::EV_ACK] = dctl_reg[eie_pkg::DCTL_ACKEN] &
      pins.rise[eie_pkg::PIN_ACK];
    if (!clk_en)
      ev = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt outputs
  assign w1c = (wr_go & adr_is(wb_adr_i, eie_pkg::OFS_STAT)) ?
    wbyte[eie_pkg::EV_N-1:0] : '0;
  // Set wins over clear
  assign stat_next = (stat_reg & ~w1c) | ev;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stat_reg <= eie_pkg::STAT_RST;
    else if (clk_en)
      stat_reg <= stat_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      irq_req_reg <= 1'b0;
    else if (clk_en)
      irq_req_reg <= |ev;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else if (clk_en)
      irq_reg <= |(stat_next & mask_reg);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      dma_en_reg <= 1'b0;
    else if (clk_en)
      dma_en_reg <= dma_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign extended_control = xctl_reg;
  assign device_control = dctl_reg;
  assign port_config_a = cfga_reg;
  assign port_config_b = cfgb_reg;
  assign dma_enabled = dma_en_reg;
  assign irq_req = irq_req_reg;
  assign irq_o = irq_reg;
endmodule // eie_top

// ### sim/eie_top_monitor.sv
// Concurrent checks on the top ports of the event logic.
// Assumes one sys_clk domain and a synchronous active-high reset.
`timescale 1ns/10ps
module eie_top_monitor
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [eie_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dma_tc,
  input wire logic dma_cycle,
  input wire logic [eie_pkg::CNT_W-1:0] fifo_free,
  input wire logic core_clk_frozen,
  input wire logic err_n_pin,
  input wire logic [eie_pkg::REG_W-1:0] extended_control,
  input wire logic [eie_pkg::REG_W-1:0] device_control,
  input wire logic [eie_pkg::REG_W-1:0] port_config_a,
  input wire logic [eie_pkg::REG_W-1:0] port_config_b,
  input wire logic dma_enabled,
  input wire logic irq_req
);
  default clocking dck @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic tc_lvl;
  logic fwd_lvl;
  assign tc_lvl = extended_control[3] && !extended_control[2] && dma_tc
    && dma_cycle;
  assign fwd_lvl = !core_clk_frozen && !device_control[5]
    && extended_control[3:2] == 2'b00;
  ////////////////////////////////////////////////////////////////////////////
  AST_ACK_ONE:
    assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_REQ:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  AST_DMA_EN:
    assert property ($past(clk_en) |-> dma_enabled ==
      $past(extended_control[3] && !extended_control[2]))
    else $error("dma enable wrong");
  AST_CFG_HIDE:
    assert property ($past(extended_control[7:5]) != 3'h7 && $past(clk_en)
      |-> $stable(port_config_a) && $stable(port_config_b))
    else $error("config changed outside mode 7");
  AST_TC:
    assert property (clk_en && tc_lvl && !$past(tc_lvl) |=> irq_req)
    else $error("terminal count lost");
  AST_FWD:
    assert property (clk_en && fwd_lvl && $past(fwd_lvl) && fifo_free >= 8
      && $past(fifo_free) < 8 |=> irq_req)
    else $error("forward threshold lost");
  AST_ERR:
    assert property (clk_en && $fell(err_n_pin) && !extended_control[4]
      && !core_clk_frozen |-> ##[2:6] irq_req)
    else $error("error edge lost");
  CV_TC: cover property (irq_req && dma_enabled);
  CV_CFG: cover property (extended_control[7:5] == 3'h7 && wb_ack_o);
  CV_ERR: cover property ($fell(err_n_pin));
endmodule // eie_top_monitor

bind eie_top eie_top_monitor mon (.*);

// ### sim/eie_far_model.sv
// Far side: DMA strobes, FIFO levels and port status pins.
// Assumes calls from the bench; pins idle high on pull-ups.
`timescale 1ns/10ps
module eie_far_model
(
  input wire logic sys_clk,
  output logic err_n_pin,
  output logic ack_n_pin,
  output logic dma_tc,
  output logic dma_cycle,
  output logic [eie_pkg::CNT_W-1:0] fifo_free,
  output logic [eie_pkg::CNT_W-1:0] fifo_fill
);
  initial
  begin
    err_n_pin = 1'b1;
    ack_n_pin = 1'b1;
    dma_tc = 1'b0;
    dma_cycle = 1'b0;
    fifo_free = 5'h00;
    fifo_fill = 5'h00;
  end
  task automatic fifo(input logic [4:0] f, input logic [4:0] b);
    @(posedge sys_clk);
    fifo_free <= f;
    fifo_fill <= b;
  endtask
  // Pin levels held long enough to pass the synchronisers
  task automatic pins(input logic e, input logic a);
    @(posedge sys_clk);
    err_n_pin <= e;
    ack_n_pin <= a;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tc_pulse();
    @(posedge sys_clk);
    dma_cycle <= 1'b1;
    @(posedge sys_clk);
    dma_tc <= 1'b1;
    @(posedge sys_clk);
    dma_tc <= 1'b0;
    dma_cycle <= 1'b0;
  endtask
endmodule // eie_far_model

// ### sim/eie_top_bench.sv
// Self-checking bench of the port interrupt event logic.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
module eie_top_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic frz = 1'b0;
  logic [1:0] fl = 2'b00;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o, rd;
  logic ack_o, tc, dcyc, err_n, ack_n, dma_en, irq;
  logic [4:0] free, fill;
  logic [7:0] xctl, dctl, cfa, cfb;
  int mismatches = 0;
  int checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  eie_top uut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .dma_tc(tc), .dma_cycle(dcyc), .fifo_free(free), .fifo_fill(fill),
    .fifo_full(fl[1]), .fifo_empty(fl[0]), .core_clk_frozen(frz),
    .err_n_pin(err_n), .ack_n_pin(ack_n), .extended_control(xctl),
    .device_control(dctl), .port_config_a(cfa), .port_config_b(cfb),
    .dma_enabled(dma_en), .irq_req(), .irq_o(irq)
  );
  eie_far_model far
  (
    .sys_clk(sys_clk), .err_n_pin(err_n), .ack_n_pin(ack_n),
    .dma_tc(tc), .dma_cycle(dcyc), .fifo_free(free), .fifo_fill(fill)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One classic cycle, released at the edge that sees ack
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    fl <= 2'b10;
    #1;
    chk("xctl", xctl, 32'h0000_0014);
    chk("dctl", dctl, 32'h0000_0000);
    chk("irq", irq, 32'h0000_0000);
    rchk("xctl read", eie_pkg::OFS_XCTL, 32'h0000_0016);
    rchk("unmapped", 8'h1C, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_cfg();
    wr(eie_pkg::OFS_CFGA, 32'h0000_005A);
    rchk("cfga hidden", eie_pkg::OFS_CFGA, 32'h0000_0000);
    chk("cfga", cfa, 32'h0000_0010);
    wr(eie_pkg::OFS_XCTL, 32'h0000_00E0);
    wr(eie_pkg::OFS_CFGB, 32'h0000_005A);
    rchk("cfgb", eie_pkg::OFS_CFGB, 32'h0000_005A);
    chk("cfgb copy", cfb, 32'h0000_005A);
    wr(eie_pkg::OFS_XCTL, 32'h0000_0014);
    $display("config test done");
  endtask
  task automatic t_svc();
    int m, d;
    logic [31:0] e, b;
    far.fifo(5'h09, 5'h09);
    wr(eie_pkg::OFS_MASK, 32'h0000_001F);
    for (m = 0; m < 7; m++)
      for (d = 0; d < 2; d++)
      begin
        e = {24'h00_0000, m[2:0], 5'h00};
        wr(eie_pkg::OFS_XCTL, e | 32'h0000_0004);
        wr(eie_pkg::OFS_DCTL, d ? 32'h0000_0020 : 32'h0000_0000);
        wr(eie_pkg::OFS_STAT, 32'h0000_001F);
        wr(eie_pkg::OFS_XCTL, e);
        settle();
        b = d ? 32'h0000_0004 : 32'h0000_0002;
        if (!(m == 3 || m == 6 || (m == 2 && d == 0)))
          b = 32'h0000_0000;
        rchk("svc clear", eie_pkg::OFS_STAT, b);
        chk("irq", irq, {31'h0000_0000, b != 0});
      end
    $display("service clear test done");
  endtask
  task automatic t_thr();
    wr(eie_pkg::OFS_XCTL, 32'h0000_0040);
    wr(eie_pkg::OFS_DCTL, 32'h0000_0000);
    far.fifo(5'h04, 5'h04);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.fifo(5'h09, 5'h04);
    settle();
    rchk("fwd", eie_pkg::OFS_STAT, 32'h0000_0002);
    wr(eie_pkg::OFS_DCTL, 32'h0000_0020);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.fifo(5'h04, 5'h09);
    settle();
    rchk("bwd", eie_pkg::OFS_STAT, 32'h0000_0004);
    chk("dctl", dctl, 32'h0000_0020);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    @(posedge sys_clk);
    frz <= 1'b1;
    far.fifo(5'h04, 5'h04);
    far.fifo(5'h04, 5'h09);
    far.pins(1'b0, 1'b1);
    far.pins(1'b1, 1'b1);
    far.fifo(5'h04, 5'h04);
    settle();
    rchk("frozen", eie_pkg::OFS_STAT, 32'h0000_0000);
    frz <= 1'b0;
    $display("threshold test done");
  endtask
  task automatic t_tc();
    wr(eie_pkg::OFS_XCTL, 32'h0000_0068);
    settle();
    chk("dma on", dma_en, 32'h0000_0001);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.tc_pulse();
    settle();
    rchk("tc", eie_pkg::OFS_STAT, 32'h0000_0001);
    wr(eie_pkg::OFS_XCTL, 32'h0000_006C);
    settle();
    chk("dma off", dma_en, 32'h0000_0000);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.tc_pulse();
    settle();
    rchk("tc svc", eie_pkg::OFS_STAT, 32'h0000_0000);
    $display("terminal count test done");
  endtask
  task automatic t_err();
    wr(eie_pkg::OFS_XCTL, 32'h0000_0060);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.pins(1'b0, 1'b1);
    settle();
    rchk("err fall", eie_pkg::OFS_STAT, 32'h0000_0008);
    far.pins(1'b1, 1'b1);
    wr(eie_pkg::OFS_XCTL, 32'h0000_0070);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.pins(1'b0, 1'b1);
    settle();
    rchk("err masked", eie_pkg::OFS_STAT, 32'h0000_0000);
    wr(eie_pkg::OFS_XCTL, 32'h0000_0060);
    settle();
    rchk("err unmask", eie_pkg::OFS_STAT, 32'h0000_0008);
    far.pins(1'b1, 1'b1);
    $display("error test done");
  endtask
  task automatic t_ack();
    wr(eie_pkg::OFS_DCTL, 32'h0000_0010);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    far.pins(1'b1, 1'b0);
    far.pins(1'b1, 1'b1);
    settle();
    rchk("ack", eie_pkg::OFS_STAT, 32'h0000_0010);
    chk("irq ack", irq, 32'h0000_0001);
    wr(eie_pkg::OFS_MASK, 32'h0000_0000);
    settle();
    chk("irq masked", irq, 32'h0000_0000);
    wr(eie_pkg::OFS_MASK, 32'h0000_0010);
    settle();
    chk("irq unmasked", irq, 32'h0000_0001);
    wr(eie_pkg::OFS_STAT, 32'h0000_0010);
    settle();
    chk("irq cleared", irq, 32'h0000_0000);
    wr(eie_pkg::OFS_DCTL, 32'h0000_0000);
    far.pins(1'b1, 1'b0);
    far.pins(1'b1, 1'b1);
    settle();
    rchk("ack off", eie_pkg::OFS_STAT, 32'h0000_0000);
    $display("acknowledge test done");
  endtask
  // Pin edges while the clock enable is low must leave no trace
  task automatic t_hold();
    wr(eie_pkg::OFS_XCTL, 32'h0000_0060);
    wr(eie_pkg::OFS_DCTL, 32'h0000_0010);
    wr(eie_pkg::OFS_STAT, 32'h0000_001F);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    far.pins(1'b0, 1'b0);
    far.pins(1'b1, 1'b1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    settle();
    chk("hold xctl", xctl, 32'h0000_0060);
    chk("hold irq", irq, 32'h0000_0000);
    rchk("hold stat", eie_pkg::OFS_STAT, 32'h0000_0000);
    $display("clock enable test done");
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_cfg();
    t_svc();
    t_thr();
    t_tc();
    t_err();
    t_ack();
    t_hold();
    finish_test();
  end
endmodule // eie_top_bench
